/* File: rtl/stc_pkg.sv */
package stc_pkg;
  // ==========================================================
  // Register map: indices, byte address is index times four
  // ==========================================================
  localparam logic [5:0] IDX_CTRL = 6'h20; // Test enable and clock select
  localparam logic [5:0] IDX_STATUS = 6'h21; // Live state of the checker
  localparam logic [5:0] IDX_IRQ_STAT = 6'h22; // Sticky events, read only
  localparam logic [5:0] IDX_IRQ_EN = 6'h23; // Event enables
  localparam logic [5:0] IDX_IRQ_CLR = 6'h24; // Write one to clear
  localparam logic [5:0] IDX_ERR_RECORD = 6'h25; // Forward error record
  // ==========================================================
  // Field positions and reset values
  // ==========================================================
  localparam int CTRL_EN_BIT = 0; // Software test enable
  localparam int CTRL_OSC_BIT = 1; // Software oscillator select
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int STAT_ACTIVE_BIT = 0; // Test running
  localparam int STAT_CHECK_BIT = 1; // Checking the stream
  localparam int STAT_LOCK_BIT = 2; // Lock indication
  localparam int STAT_PASS_BIT = 3; // Current result pin level
  localparam int EV_FRAME_ERR = 0; // Errored frame seen
  localparam int EV_DONE = 1; // Test ended
  localparam int EV_LOCK_LOST = 2; // Lock dropped while checking
  localparam int NUM_EV = 3;
  localparam logic [2:0] IRQ_EN_RESET = 3'h0;
  // ==========================================================
  // Data path sizes and bus answers
  // ==========================================================
  localparam int PAYLOAD_W = 35; // Payload bits checked per symbol
  localparam int CNT_W = 8; // Error record width
  localparam logic [7:0] CNT_MAX = 8'hFF; // Record saturates here
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // Checker states
  // ==========================================================
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_CHECK
  } stc_state_t;
endpackage

/* File: rtl/stc_sticky.sv */
`timescale 1ns/10ps
// ============================================================
// Sticky event bits: set wins over a clear in the same cycle
// ============================================================
module stc_sticky #(
  parameter int W = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  output logic [W-1:0] q
);
  // Event is never lost when software clears in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else if (ce) begin
      q <= (q & ~clr) | set;
    end
  end
endmodule

/* File: rtl/stc_checker.sv */
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/10ps
// Function
// - Enter test on pin or register enable
// - Test clock is pixel or oscillator
// - Oscillator selectable by pin or register
// - Send enable and wake over back channel
// - On both-in-test plus lock, pass high
// - Count errors, readable at index forward_error_record
// - Errored frame pulses result pin low
// - Check payload bits one to thirty-five
// - Result pin holds verdict after test
// - Test lasts while enable held high
// - Lock loss clears error count
// - Lock indication valid throughout test
// - Step equalizer when leaving test
module stc_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic self_test_enable_pin,
  input wire logic self_test_clock_select_pin,
  input wire logic link_lock,
  input wire logic remote_test_ack,
  input wire logic sym_valid,
  input wire logic [stc_pkg::PAYLOAD_W-1:0] sym_payload,
  input wire logic frame_end,
  output logic pass_pin,
  output logic bc_test_enable,
  output logic bc_wake,
  output logic use_internal_oscillator,
  output logic lock_status,
  output logic adaptive_equalizer_step,
  output logic irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ==========================================================
  // State
  // ==========================================================
  stc_pkg::stc_state_t state; // Checker sequence
  logic [1:0] ctrl; // Software enable and clock select
  logic [stc_pkg::NUM_EV-1:0] irq_en; // Event enables
  logic [stc_pkg::NUM_EV-1:0] irq_stat; // Sticky events
  logic [stc_pkg::CNT_W-1:0] err_count; // Forward error record
  logic frame_acc; // Error seen earlier in this frame
  logic verdict_err; // Errors seen in the current run
  logic [7:0] aw_addr; // Latched write address
  logic [31:0] w_data; // Latched write data
  logic [3:0] w_strb; // Latched write strobes
  logic aw_held; // Write address taken
  logic w_held; // Write data taken
  // ==========================================================
  // Decode
  // ==========================================================
  wire en_any = self_test_enable_pin | ctrl[stc_pkg::CTRL_EN_BIT];
  wire osc_sel = self_test_clock_select_pin | ctrl[stc_pkg::CTRL_OSC_BIT];
  wire sym_bad = sym_valid & (|sym_payload);
  wire frame_bad = frame_acc | sym_bad; // Whole frame verdict
  wire in_check = (state == stc_pkg::ST_CHECK);
  wire start = (state == stc_pkg::ST_IDLE) & en_any;
  wire stop = (state != stc_pkg::ST_IDLE) & ~en_any;
  wire lock_go = (state == stc_pkg::ST_WAIT) & en_any & remote_test_ack & link_lock;
  wire lock_drop = in_check & en_any & ~link_lock;
  wire err_frame = in_check & en_any & link_lock & frame_end & frame_bad;
  wire [stc_pkg::NUM_EV-1:0] ev_set = {lock_drop, stop, err_frame};
  wire do_write = aw_held & w_held & ~s_axi_bvalid;
  wire [5:0] wr_idx = aw_addr[7:2];
  wire [5:0] rd_idx = s_axi_araddr[7:2];
  wire wr_ctrl = do_write & (wr_idx == stc_pkg::IDX_CTRL) & w_strb[0];
  wire wr_en = do_write & (wr_idx == stc_pkg::IDX_IRQ_EN) & w_strb[0];
  wire wr_clr = do_write & (wr_idx == stc_pkg::IDX_IRQ_CLR) & w_strb[0];
  wire [stc_pkg::NUM_EV-1:0] ev_clr = wr_clr ? w_data[stc_pkg::NUM_EV-1:0] : '0;
  wire wr_hit = (wr_idx >= stc_pkg::IDX_CTRL) & (wr_idx <= stc_pkg::IDX_ERR_RECORD);
  wire rd_hit = (rd_idx >= stc_pkg::IDX_CTRL) & (rd_idx <= stc_pkg::IDX_ERR_RECORD);
  wire [3:0] status = {pass_pin, lock_status, in_check, state != stc_pkg::ST_IDLE};
  wire [7:0] rd_val =
    (rd_idx == stc_pkg::IDX_CTRL) ? {6'h00, ctrl} :
    (rd_idx == stc_pkg::IDX_STATUS) ? {4'h0, status} :
    (rd_idx == stc_pkg::IDX_IRQ_STAT) ? {5'h00, irq_stat} :
    (rd_idx == stc_pkg::IDX_IRQ_EN) ? {5'h00, irq_en} :
    (rd_idx == stc_pkg::IDX_ERR_RECORD) ? err_count : 8'h00;
  // ==========================================================
  // Sequence
  // ==========================================================
  // Idle, wait for far end and lock, then check frames
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= stc_pkg::ST_IDLE;
    end else if (ce) begin
      case (state)
        stc_pkg::ST_IDLE: begin
          if (en_any) begin
            state <= stc_pkg::ST_WAIT;
          end
        end
        stc_pkg::ST_WAIT: begin
          if (!en_any) begin
            state <= stc_pkg::ST_IDLE;
          end else if (lock_go) begin
            state <= stc_pkg::ST_CHECK;
          end
        end
        stc_pkg::ST_CHECK: begin
          if (!en_any) begin
            state <= stc_pkg::ST_IDLE;
          end else if (!link_lock) begin
            state <= stc_pkg::ST_WAIT; // Relock before checking again
          end
        end
        default: begin
          state <= stc_pkg::ST_IDLE;
        end
      endcase
    end
  end
  // ==========================================================
  // Error checking
  // ==========================================================
  // Frame accumulator: a frame counts once however many symbols fail
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_acc <= 1'b0;
    end else if (ce) begin
      frame_acc <= in_check & ~frame_end & frame_bad;
    end
  end
  // Error record saturates so a long run never wraps to zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_count <= '0;
    end else if (ce) begin
      if (start || lock_go || lock_drop) begin
        err_count <= '0;
      end else if (err_frame && err_count != stc_pkg::CNT_MAX) begin
        err_count <= err_count + 8'h01;
      end
    end
  end
  // Verdict of the current run
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      verdict_err <= 1'b0;
    end else if (ce) begin
      if (lock_go) begin
        verdict_err <= 1'b0;
      end else if (err_frame) begin
        verdict_err <= 1'b1;
      end
    end
  end
  // Result pin: one clock low per errored frame; the clock is the
  // recovered pixel clock here, so a full period stands in for half
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pass_pin <= 1'b1;
    end else if (ce) begin
      if (lock_go) begin
        pass_pin <= 1'b1;
      end else if (err_frame) begin
        pass_pin <= 1'b0;
      end else if (stop) begin
        pass_pin <= ~verdict_err;
      end else if (in_check) begin
        pass_pin <= 1'b1;
      end
    end
  end
  // ==========================================================
  // Link side outputs
  // ==========================================================
  // Back channel enable follows the test; wake pulses on entry
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bc_test_enable <= 1'b0;
      bc_wake <= 1'b0;
      use_internal_oscillator <= 1'b0;
      lock_status <= 1'b0;
      adaptive_equalizer_step <= 1'b0;
    end else if (ce) begin
      bc_test_enable <= (state == stc_pkg::ST_IDLE) ? en_any : ~stop;
      bc_wake <= start;
      use_internal_oscillator <= osc_sel;
      lock_status <= link_lock;
      adaptive_equalizer_step <= stop;
    end
  end
  // ==========================================================
  // Interrupts
  // ==========================================================
  stc_sticky #(
    .W(stc_pkg::NUM_EV)
  ) u_sticky (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .set(ev_set),
    .clr(ev_clr),
    .q(irq_stat)
  );
  // Level output, registered so it comes straight from a flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(irq_stat & irq_en);
    end
  end
  // ==========================================================
  // Registers written by software
  // ==========================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= stc_pkg::CTRL_RESET;
      irq_en <= stc_pkg::IRQ_EN_RESET;
    end else if (ce) begin
      if (wr_ctrl) begin
        ctrl <= w_data[1:0];
      end
      if (wr_en) begin
        irq_en <= w_data[stc_pkg::NUM_EV-1:0];
      end
    end
  end
  // ==========================================================
  // Bus slave: write path
  // ==========================================================
  // Address and data are taken in either order, answer after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= stc_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? stc_pkg::RESP_OKAY : stc_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end
  // ==========================================================
  // Bus slave: read path
  // ==========================================================
  // One read at a time; data valid the cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= stc_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rd_val};
        s_axi_rresp <= rd_hit ? stc_pkg::RESP_OKAY : stc_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
  // ==========================================================
  // Checks
  // ==========================================================
  chk_enter_on_enable: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && start |=> state == stc_pkg::ST_WAIT && bc_wake && bc_test_enable)
    else $error("test not entered on enable");
  chk_osc_follows_select: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && osc_sel |=> use_internal_oscillator)
    else $error("oscillator select not followed");
  chk_check_on_lock: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && lock_go |=> pass_pin && state == stc_pkg::ST_CHECK && err_count == 8'h00)
    else $error("checking did not start on lock");
  chk_error_pulse_low: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && err_frame && err_count != stc_pkg::CNT_MAX |=>
    !pass_pin && err_count == $past(err_count) + 8'h01)
    else $error("errored frame not flagged");
  chk_clean_frame_high: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && in_check && link_lock && en_any && !frame_bad && !lock_go |=> pass_pin)
    else $error("clean frame pulled pass low");
  chk_verdict_holds: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && stop && verdict_err |=> !pass_pin ##1 (!ce || start || !pass_pin))
    else $error("failing verdict not held");
  chk_lock_loss_clear: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && lock_drop |=> err_count == 8'h00 && state == stc_pkg::ST_WAIT)
    else $error("lock loss kept the error count");
  chk_lock_mirror: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce |=> lock_status == $past(link_lock))
    else $error("lock indication lagging");
  chk_aeq_on_exit: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && stop |=> adaptive_equalizer_step && state == stc_pkg::ST_IDLE && !bc_test_enable)
    else $error("equalizer not stepped on exit");
endmodule

/* File: verif/stc_far_end.sv */
`timescale 1ns/10ps
// ==========================================================
// Far-end serializer model: test frames on request
// ==========================================================
module stc_far_end (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic bc_test_enable,
  input wire logic lock_drop,
  input wire logic [stc_pkg::PAYLOAD_W-1:0] err_pat,
  input wire logic [3:0] strap_io,
  output logic [7:0] crc_err_rec,
  output logic remote_test_ack,
  output logic link_lock,
  output logic sym_valid,
  output logic [stc_pkg::PAYLOAD_W-1:0] sym_payload,
  output logic frame_end
);
  logic [1:0] idx; // Slot within a four-symbol frame
  logic run; // Sending test frames
  assign run = remote_test_ack && link_lock;
  // Idle payload toggles so a stale value never looks like clean data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      remote_test_ack <= 1'b0;
      link_lock <= 1'b0;
      sym_valid <= 1'b0;
      frame_end <= 1'b0;
      sym_payload <= '0;
      idx <= 2'h0;
      crc_err_rec <= 8'h00;
    end else begin
      // Far end joins the test only with the io straps in place
      remote_test_ack <= bc_test_enable && strap_io == 4'h1;
      // Back-channel error record: cleared on entry, kept after the run
      if (bc_test_enable && !remote_test_ack) begin
        crc_err_rec <= 8'h00;
      end else if (remote_test_ack && lock_drop && link_lock) begin
        crc_err_rec <= crc_err_rec + 8'h01;
      end
      link_lock <= !lock_drop;
      sym_valid <= run;
      frame_end <= run && idx == 2'h3;
      // Zeros except the injected pattern in slot one
      sym_payload <= run ? ((idx == 2'h1) ? err_pat : '0) : ~sym_payload;
      idx <= run ? idx + 2'h1 : 2'h0;
    end
  end
endmodule

/* File: verif/test_serial_link_self_test_checker.sv */
`timescale 1ns/10ps
// ==========================================================
// Bench for the self-test checker
// ==========================================================
module test_serial_link_self_test_checker;
  logic aclk, aresetn, ten_pin, osc_pin, lock_drop, ack, lock, sv, fe;
  logic [34:0] err_pat, pay;
  logic [3:0] strap_io;
  logic [7:0] crc_rec;
  logic pass_pin, bc_test_enable, bc_wake, use_osc, lock_status, aeq_step, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp;
  int err_count, num_checks, cyc, low_cyc, step_cnt, wake_cnt;
  // 25 MHz clock
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  stc_checker dut_u (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .self_test_enable_pin(ten_pin), .self_test_clock_select_pin(osc_pin),
    .link_lock(lock), .remote_test_ack(ack), .sym_valid(sv), .sym_payload(pay),
    .frame_end(fe), .pass_pin(pass_pin), .bc_test_enable(bc_test_enable),
    .bc_wake(bc_wake), .use_internal_oscillator(use_osc), .lock_status(lock_status),
    .adaptive_equalizer_step(aeq_step), .irq(irq), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  stc_far_end far_u (.aclk(aclk), .aresetn(aresetn), .bc_test_enable(bc_test_enable),
    .lock_drop(lock_drop), .err_pat(err_pat), .strap_io(strap_io), .crc_err_rec(crc_rec),
    .remote_test_ack(ack), .link_lock(lock),
    .sym_valid(sv), .sym_payload(pay), .frame_end(fe));
  // ==========================================================
  // Helpers
  // ==========================================================
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  task automatic final_report();
    if (err_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask
  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [5:0] idx, input logic [31:0] d, input logic [1:0] er);
    logic aw_d, w_d;
    @(posedge aclk);
    awaddr <= {idx, 2'h0};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_d = 1'b0;
    w_d = 1'b0;
    while (!(aw_d && w_d)) begin
      @(posedge aclk);
      if (!aw_d && awready === 1'b1) begin
        aw_d = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_d && wready === 1'b1) begin
        w_d = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    bready <= 1'b0;
    chk("bresp", er, bresp);
  endtask
  task automatic rd(input logic [5:0] idx, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    rready <= 1'b0;
    chk("rresp", er, rresp);
    chk("rdata", e, rdata);
  endtask
  task automatic wait_fe(input int n);
    repeat (n) do @(posedge aclk); while (fe !== 1'b1);
  endtask
  // Pattern lands in exactly n frames
  task automatic inject(input logic [34:0] p, input int n);
    wait_fe(1);
    err_pat <= p;
    wait_fe(n);
    err_pat <= '0;
  endtask
  // Edge counters and the run limit
  always @(posedge aclk) begin
    cyc++;
    if (pass_pin === 1'b0 && bc_test_enable === 1'b1) low_cyc++;
    if (aeq_step === 1'b1) step_cnt++;
    if (bc_wake === 1'b1) wake_cnt++;
    if (cyc == 20000) begin
      err_count++;
      final_report();
    end
  end
  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_reset();
    chk("pass_pin", 1, pass_pin);
    rd(stc_pkg::IDX_ERR_RECORD, 0, stc_pkg::RESP_OKAY);
    rd(6'h30, 0, stc_pkg::RESP_SLVERR);
    wr(6'h30, 1, stc_pkg::RESP_SLVERR);
    rd(stc_pkg::IDX_IRQ_EN, 0, stc_pkg::RESP_OKAY);
  endtask
  task automatic t_osc();
    @(posedge aclk);
    osc_pin <= 1'b1;
    settle(3);
    chk("osc pin", 1, use_osc);
    @(posedge aclk);
    osc_pin <= 1'b0;
    wr(stc_pkg::IDX_CTRL, 2, stc_pkg::RESP_OKAY);
    settle(2);
    chk("osc reg", 1, use_osc);
    rd(stc_pkg::IDX_CTRL, 2, stc_pkg::RESP_OKAY);
    wr(stc_pkg::IDX_CTRL, 0, stc_pkg::RESP_OKAY);
    settle(2);
    chk("osc off", 0, use_osc);
  endtask
  // Register-started run, errors at both payload ends, masked then enabled irq
  task automatic t_err_run();
    low_cyc = 0;
    wr(stc_pkg::IDX_CTRL, 1, stc_pkg::RESP_OKAY);
    wait_fe(2);
    inject(35'h400000000, 1);
    settle(2);
    chk("irq masked", 0, irq);
    wr(stc_pkg::IDX_IRQ_EN, 1, stc_pkg::RESP_OKAY);
    settle(3);
    chk("irq", 1, irq);
    inject(35'h000000001, 1);
    settle(2);
    chk("low cycles", 2, low_cyc);
    rd(stc_pkg::IDX_ERR_RECORD, 2, stc_pkg::RESP_OKAY);
    rd(stc_pkg::IDX_IRQ_STAT, 1, stc_pkg::RESP_OKAY);
    wr(stc_pkg::IDX_IRQ_CLR, 1, stc_pkg::RESP_OKAY);
    settle(3);
    chk("irq clr", 0, irq);
    wr(stc_pkg::IDX_CTRL, 0, stc_pkg::RESP_OKAY);
    settle(4);
    chk("verdict", 0, pass_pin);
    chk("bc enable", 0, bc_test_enable);
    chk("aeq step", 1, step_cnt);
    chk("wake", 1, wake_cnt);
  endtask
  // Pin-started clean run clears the old verdict
  task automatic t_clean_run();
    @(posedge aclk);
    ten_pin <= 1'b1;
    settle(2);
    chk("bc enable", 1, bc_test_enable);
    wait_fe(1);
    settle(1);
    chk("pass start", 1, pass_pin);
    chk("lock", 1, lock_status);
    wait_fe(3);
    @(posedge aclk);
    ten_pin <= 1'b0;
    settle(4);
    chk("verdict", 1, pass_pin);
    chk("aeq step", 2, step_cnt);
    rd(stc_pkg::IDX_ERR_RECORD, 0, stc_pkg::RESP_OKAY);
  endtask
  task automatic t_lock_loss();
    @(posedge aclk);
    ten_pin <= 1'b1;
    wait_fe(2);
    inject(35'h400000000, 1);
    settle(2);
    rd(stc_pkg::IDX_ERR_RECORD, 1, stc_pkg::RESP_OKAY);
    @(posedge aclk);
    lock_drop <= 1'b1;
    settle(3);
    chk("lock", 0, lock_status);
    @(posedge aclk);
    lock_drop <= 1'b0;
    wait_fe(2);
    rd(stc_pkg::IDX_ERR_RECORD, 0, stc_pkg::RESP_OKAY);
    rd(stc_pkg::IDX_IRQ_STAT, 7, stc_pkg::RESP_OKAY);
    @(posedge aclk);
    ten_pin <= 1'b0;
    settle(3);
    chk("crc record", 1, crc_rec);
  endtask
  initial begin
    aresetn = 1'b0;
    ten_pin = 1'b0;
    osc_pin = 1'b0;
    lock_drop = 1'b0;
    err_pat = '0;
    strap_io = 4'h1;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    settle(1);
    t_reset();
    t_osc();
    t_err_run();
    t_clean_run();
    t_lock_loss();
    final_report();
  end
endmodule
